// [core/srf_consts.svh]
// Constants for the shift, rotate and flag unit
`ifndef SRF_CONSTS_SVH
`define SRF_CONSTS_SVH
`define SRF_FLAG_C 3'h0
`define SRF_FLAG_Z 3'h1
`define SRF_FLAG_N 3'h2
`define SRF_FLAG_V 3'h3
`define SRF_FLAG_S 3'h4
`define SRF_FLAG_H 3'h5
`define SRF_FLAG_T 3'h6
`define SRF_FLAG_I 3'h7
`define SRF_FLAGS_RST 8'h00
`define SRF_REG_RST 8'h00
`endif

// [core/srf_pkg.sv]
// Types for the shift, rotate and flag unit
package srf_pkg;
  typedef enum logic [3:0] {
    SRF_NOP = 4'h0,
    SRF_LOGICAL_RIGHT_SHIFT = 4'h1,
    SRF_ROTATE_LEFT_CARRY = 4'h2,
    SRF_ROTATE_RIGHT_CARRY = 4'h3,
    SRF_ARITH_RIGHT_SHIFT = 4'h4,
    SRF_NIBBLE_SWAP = 4'h5,
    SRF_FLAG_SET_BY_INDEX = 4'h6,
    SRF_FLAG_CLEAR_BY_INDEX = 4'h7,
    SRF_REG_BIT_TO_TRANSFER = 4'h8,
    SRF_TRANSFER_TO_REG_BIT = 4'h9,
    SRF_CARRY_SET_OP = 4'hA,
    SRF_CARRY_CLEAR_OP = 4'hB,
    SRF_NEGATIVE_SET_OP = 4'hC,
    SRF_NEGATIVE_CLEAR_OP = 4'hD,
    SRF_ZERO_SET_OP = 4'hE,
    SRF_ZERO_CLEAR_OP = 4'hF
  } srf_op_type;
endpackage : srf_pkg

// [core/srf_regfile.sv]
// General-purpose register file, 32 x 8, registered read ports
`timescale 1ns/1ps
`default_nettype none
`include "srf_consts.svh"
module srf_regfile (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] mem_q [0:31];

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_word
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[gi] <= `SRF_REG_RST;
        end else if (wr_en && wr_addr == 5'(gi)) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_a <= `SRF_REG_RST;
      rd_data_b <= `SRF_REG_RST;
    end else begin
      rd_data_a <= (wr_en && wr_addr == rd_addr_a) ? wr_data : mem_q[rd_addr_a];
      rd_data_b <= (wr_en && wr_addr == rd_addr_b) ? wr_data : mem_q[rd_addr_b];
    end
  end
endmodule : srf_regfile
`default_nettype wire

// [core/srf_unit.sv]
// Shift, rotate and status-flag execution unit
// Notes on behaviour
// RULE_01 - Logical right shift moves bits toward bit 0, loads 0 into bit 7, sets Z C N V, one cycle.
// RULE_02 - Rotate left through carry puts old C in bit 0, old bit 7 in C, sets Z C N V.
// RULE_03 - Rotate right through carry puts old C in bit 7, old bit 0 in C, sets Z C N V.
// RULE_04 - Arithmetic right shift keeps bit 7 and shifts bits 1..7 down, sets Z C N V.
// RULE_05 - Nibble swap exchanges the two halves in one cycle and leaves all flags alone.
// RULE_06 - Indexed flag set writes 1 into only the selected status bit in one cycle.
// RULE_07 - Indexed flag clear writes 0 into only the selected status bit in one cycle.
// RULE_08 - Register bit to transfer copies the selected source bit into T and nothing else.
// RULE_09 - Transfer to register bit copies T into the selected bit, other bits and flags kept.
// RULE_10 - Carry set and clear force C to 1 or 0 in one cycle touching no other flag.
// RULE_11 - Negative set and clear force N to 1 or 0 in one cycle.
// RULE_12 - Zero set and clear force Z to 1 or 0 in one cycle.
// RULE_13 - Interrupt enable sets the global I flag in one cycle.
// RULE_14 - Flags not named as affected by an operation keep their values.
`timescale 1ns/1ps
`default_nettype none
`include "srf_consts.svh"
module srf_unit
  import srf_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic INT_ENABLE_OP,
  input wire logic [4:0] DEST_SEL,
  input wire logic [4:0] SRC_SEL,
  input wire logic [2:0] BIT_INDEX,
  input wire logic LOAD_EN,
  input wire logic [4:0] LOAD_ADDR,
  input wire logic [7:0] LOAD_DATA,
  input wire logic [4:0] PEEK_ADDR,
  output logic [7:0] PEEK_DATA,
  output logic [7:0] STATUS_FLAGS,
  output logic [7:0] RESULT,
  output logic BUSY
);
  srf_op_type op_q;
  logic exec_q;
  logic ie_q;
  logic [2:0] idx_q;
  logic [4:0] dest_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] rd_val;
  logic [7:0] src_val;
  logic [7:0] res_d;
  logic res_wr;
  logic new_c;
  logic [4:0] addr_a;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;

  // Sets N, Z, C and V from a shift result; V is N xor C, S and H are kept
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
                                             input logic c);
    logic [7:0] o;
    o = f;
    o[`SRF_FLAG_C] = c;
    o[`SRF_FLAG_Z] = (r == 8'h00);
    o[`SRF_FLAG_N] = r[7];
    o[`SRF_FLAG_V] = r[7] ^ c;
    return o; // RULE_14
  endfunction : shift_flags

  // Operands fetched in the issue cycle, executed in the next cycle, written back on the edge after
  assign addr_a = OP_VALID ? DEST_SEL : PEEK_ADDR;

  srf_regfile i_srf_regfile (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .rd_addr_a(addr_a),
    .rd_addr_b(SRC_SEL),
    .rd_data_a(rd_val),
    .rd_data_b(src_val),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      op_q <= SRF_NOP;
      exec_q <= 1'b0;
      ie_q <= 1'b0;
      idx_q <= 3'h0;
      dest_q <= 5'h00;
    end else begin
      op_q <= srf_op_type'(OP_CODE);
      exec_q <= OP_VALID;
      ie_q <= OP_VALID && INT_ENABLE_OP;
      idx_q <= BIT_INDEX;
      dest_q <= DEST_SEL;
    end
  end

  always_comb begin
    flags_d = flags_q;
    res_d = rd_val;
    res_wr = 1'b0;
    new_c = 1'b0;
    if (exec_q && ie_q) begin
      flags_d[`SRF_FLAG_I] = 1'b1; // RULE_13
    end else if (exec_q) begin
      case (op_q)
        SRF_LOGICAL_RIGHT_SHIFT: begin
          res_d = {1'b0, rd_val[7:1]}; // RULE_01
          new_c = rd_val[0];
          res_wr = 1'b1;
          flags_d = shift_flags(flags_q, res_d, new_c); // RULE_01
        end
        SRF_ROTATE_LEFT_CARRY: begin
          res_d = {rd_val[6:0], flags_q[`SRF_FLAG_C]}; // RULE_02
          new_c = rd_val[7];
          res_wr = 1'b1;
          flags_d = shift_flags(flags_q, res_d, new_c); // RULE_02
        end
        SRF_ROTATE_RIGHT_CARRY: begin
          res_d = {flags_q[`SRF_FLAG_C], rd_val[7:1]}; // RULE_03
          new_c = rd_val[0];
          res_wr = 1'b1;
          flags_d = shift_flags(flags_q, res_d, new_c); // RULE_03
        end
        SRF_ARITH_RIGHT_SHIFT: begin
          res_d = {rd_val[7], rd_val[7:1]}; // RULE_04
          new_c = rd_val[0];
          res_wr = 1'b1;
          flags_d = shift_flags(flags_q, res_d, new_c); // RULE_04
        end
        SRF_NIBBLE_SWAP: begin
          res_d = {rd_val[3:0], rd_val[7:4]}; // RULE_05
          res_wr = 1'b1;
        end
        SRF_FLAG_SET_BY_INDEX: flags_d[idx_q] = 1'b1; // RULE_06
        SRF_FLAG_CLEAR_BY_INDEX: flags_d[idx_q] = 1'b0; // RULE_07
        SRF_REG_BIT_TO_TRANSFER: flags_d[`SRF_FLAG_T] = src_val[idx_q]; // RULE_08
        SRF_TRANSFER_TO_REG_BIT: begin
          res_d[idx_q] = flags_q[`SRF_FLAG_T]; // RULE_09
          res_wr = 1'b1;
        end
        SRF_CARRY_SET_OP: flags_d[`SRF_FLAG_C] = 1'b1; // RULE_10
        SRF_CARRY_CLEAR_OP: flags_d[`SRF_FLAG_C] = 1'b0; // RULE_10
        SRF_NEGATIVE_SET_OP: flags_d[`SRF_FLAG_N] = 1'b1; // RULE_11
        SRF_NEGATIVE_CLEAR_OP: flags_d[`SRF_FLAG_N] = 1'b0; // RULE_11
        SRF_ZERO_SET_OP: flags_d[`SRF_FLAG_Z] = 1'b1; // RULE_12
        SRF_ZERO_CLEAR_OP: flags_d[`SRF_FLAG_Z] = 1'b0; // RULE_12
        default: flags_d = flags_q; // RULE_14
      endcase
    end
  end

  // Execution writeback outranks an external load
  assign wr_en = res_wr || LOAD_EN;
  assign wr_addr = res_wr ? dest_q : LOAD_ADDR;
  assign wr_data = res_wr ? res_d : LOAD_DATA;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= `SRF_FLAGS_RST;
    end else begin
      flags_q <= flags_d; // RULE_14
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RESULT <= 8'h00;
    end else if (res_wr) begin
      RESULT <= res_d;
    end
  end

  assign PEEK_DATA = rd_val;
  assign STATUS_FLAGS = flags_q;
  assign BUSY = exec_q;

  AST_LOGIC_SHR_RESULT: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_01
    exec_q && !ie_q && op_q == SRF_LOGICAL_RIGHT_SHIFT |=> RESULT == {1'b0, $past(rd_val[7:1])}
      && STATUS_FLAGS[`SRF_FLAG_C] == $past(rd_val[0]))
    else $error("logical right shift wrong");
  AST_ROT_LEFT_RESULT: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_02
    exec_q && !ie_q && op_q == SRF_ROTATE_LEFT_CARRY |=> RESULT[0] == $past(flags_q[0])
      && STATUS_FLAGS[`SRF_FLAG_C] == $past(rd_val[7]))
    else $error("rotate left through carry wrong");
  AST_ROT_RIGHT_RESULT: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_03
    exec_q && !ie_q && op_q == SRF_ROTATE_RIGHT_CARRY |=> RESULT[7] == $past(flags_q[0])
      && STATUS_FLAGS[`SRF_FLAG_C] == $past(rd_val[0]))
    else $error("rotate right through carry wrong");
  AST_ARITH_SHR_SIGN: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_04
    exec_q && !ie_q && op_q == SRF_ARITH_RIGHT_SHIFT |=>
      RESULT == {$past(rd_val[7]), $past(rd_val[7:1])})
    else $error("arithmetic shift lost sign");
  AST_SHIFT_KEEPS_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_14
    exec_q && !ie_q && (op_q == SRF_LOGICAL_RIGHT_SHIFT || op_q == SRF_ROTATE_LEFT_CARRY
      || op_q == SRF_ROTATE_RIGHT_CARRY || op_q == SRF_ARITH_RIGHT_SHIFT) |=>
      STATUS_FLAGS[7:4] == $past(flags_q[7:4]))
    else $error("shift touched an unnamed flag");
  AST_SWAP_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_05
    exec_q && !ie_q && op_q == SRF_NIBBLE_SWAP |=> $stable(STATUS_FLAGS)
      && RESULT == {$past(rd_val[3:0]), $past(rd_val[7:4])})
    else $error("nibble swap wrong");
  AST_FLAG_SET_IDX: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_06
    exec_q && !ie_q && op_q == SRF_FLAG_SET_BY_INDEX |=>
      STATUS_FLAGS == ($past(flags_q) | (8'h01 << $past(idx_q))))
    else $error("indexed flag set wrong");
  AST_FLAG_CLR_IDX: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_07
    exec_q && !ie_q && op_q == SRF_FLAG_CLEAR_BY_INDEX |=>
      STATUS_FLAGS == ($past(flags_q) & ~(8'h01 << $past(idx_q))))
    else $error("indexed flag clear wrong");
  AST_BIT_TO_T: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_08
    exec_q && !ie_q && op_q == SRF_REG_BIT_TO_TRANSFER |=>
      STATUS_FLAGS[`SRF_FLAG_T] == $past(src_val[idx_q])
      && STATUS_FLAGS[5:0] == $past(flags_q[5:0]))
    else $error("bit to transfer wrong");
  AST_T_TO_BIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_09
    exec_q && !ie_q && op_q == SRF_TRANSFER_TO_REG_BIT |=>
      RESULT[$past(idx_q)] == $past(flags_q[6]) && $stable(STATUS_FLAGS))
    else $error("transfer to bit wrong");
  AST_CARRY_OPS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_10
    exec_q && !ie_q && (op_q == SRF_CARRY_SET_OP || op_q == SRF_CARRY_CLEAR_OP) |=>
      STATUS_FLAGS == {$past(flags_q[7:1]), $past(op_q == SRF_CARRY_SET_OP)})
    else $error("carry op wrong");
  AST_NEG_OPS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_11
    exec_q && !ie_q && (op_q == SRF_NEGATIVE_SET_OP || op_q == SRF_NEGATIVE_CLEAR_OP) |=>
      STATUS_FLAGS[`SRF_FLAG_N] == $past(op_q == SRF_NEGATIVE_SET_OP))
    else $error("negative op wrong");
  AST_ZERO_OPS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_12
    exec_q && !ie_q && (op_q == SRF_ZERO_SET_OP || op_q == SRF_ZERO_CLEAR_OP) |=>
      STATUS_FLAGS[`SRF_FLAG_Z] == $past(op_q == SRF_ZERO_SET_OP))
    else $error("zero op wrong");
  AST_IE_OP: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_13
    OP_VALID && INT_ENABLE_OP |=> ##1 STATUS_FLAGS[`SRF_FLAG_I]
      && STATUS_FLAGS[6:0] == $past(flags_q[6:0]))
    else $error("interrupt enable wrong");
  AST_IDLE_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE_14
    !exec_q |=> $stable(STATUS_FLAGS))
    else $error("flags moved without operation");
endmodule : srf_unit
`default_nettype wire

// [verif/tb_srf_unit.sv]
// Self-checking testbench for the shift, rotate and flag unit
`timescale 1ns/1ps
`default_nettype none
`include "srf_consts.svh"
module tb_srf_unit;
  import srf_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic OP_VALID = 1'b0;
  logic [3:0] OP_CODE = 4'h0;
  logic INT_ENABLE_OP = 1'b0;
  logic [4:0] DEST_SEL = 5'h00;
  logic [4:0] SRC_SEL = 5'h00;
  logic [2:0] BIT_INDEX = 3'h0;
  logic LOAD_EN = 1'b0;
  logic [4:0] LOAD_ADDR = 5'h00;
  logic [7:0] LOAD_DATA = 8'h00;
  logic [4:0] PEEK_ADDR = 5'h00;
  logic [7:0] PEEK_DATA;
  logic [7:0] STATUS_FLAGS;
  logic [7:0] RESULT;
  logic BUSY;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] exp_reg [32];
  logic [7:0] exp_flags = `SRF_FLAGS_RST;

  always #20 SYS_CLK = ~SYS_CLK;

  srf_unit i_srf_unit (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .INT_ENABLE_OP(INT_ENABLE_OP), .DEST_SEL(DEST_SEL), .SRC_SEL(SRC_SEL),
    .BIT_INDEX(BIT_INDEX), .LOAD_EN(LOAD_EN), .LOAD_ADDR(LOAD_ADDR),
    .LOAD_DATA(LOAD_DATA), .PEEK_ADDR(PEEK_ADDR), .PEEK_DATA(PEEK_DATA),
    .STATUS_FLAGS(STATUS_FLAGS), .RESULT(RESULT), .BUSY(BUSY)
  );

  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8

  task automatic load(input logic [4:0] a, input logic [7:0] d);
    @(negedge SYS_CLK);
    LOAD_EN = 1'b1;
    LOAD_ADDR = a;
    LOAD_DATA = d;
    @(negedge SYS_CLK);
    LOAD_EN = 1'b0;
    exp_reg[a] = d;
  endtask : load

  task automatic peek(input logic [4:0] a);
    @(negedge SYS_CLK);
    PEEK_ADDR = a;
    @(negedge SYS_CLK);
    check8(PEEK_DATA, exp_reg[a], "register");
  endtask : peek

  // Issue one operation, predict its effect, compare after the writeback edge
  task automatic run_op(input srf_op_type op, input logic [4:0] d, input logic [4:0] s,
                        input logic [2:0] b, input logic ie);
    logic [7:0] v;
    logic [7:0] r;
    logic shf;
    v = exp_reg[d];
    r = v;
    shf = !ie && op >= SRF_LOGICAL_RIGHT_SHIFT && op <= SRF_ARITH_RIGHT_SHIFT;
    if (ie) exp_flags[`SRF_FLAG_I] = 1'b1;
    case (ie ? SRF_NOP : op)
      SRF_LOGICAL_RIGHT_SHIFT: r = {1'b0, v[7:1]};
      SRF_ROTATE_LEFT_CARRY: r = {v[6:0], exp_flags[`SRF_FLAG_C]};
      SRF_ROTATE_RIGHT_CARRY: r = {exp_flags[`SRF_FLAG_C], v[7:1]};
      SRF_ARITH_RIGHT_SHIFT: r = {v[7], v[7:1]};
      SRF_NIBBLE_SWAP: r = {v[3:0], v[7:4]};
      SRF_FLAG_SET_BY_INDEX: exp_flags[b] = 1'b1;
      SRF_FLAG_CLEAR_BY_INDEX: exp_flags[b] = 1'b0;
      SRF_REG_BIT_TO_TRANSFER: exp_flags[`SRF_FLAG_T] = exp_reg[s][b];
      SRF_TRANSFER_TO_REG_BIT: r[b] = exp_flags[`SRF_FLAG_T];
      SRF_CARRY_SET_OP: exp_flags[`SRF_FLAG_C] = 1'b1;
      SRF_CARRY_CLEAR_OP: exp_flags[`SRF_FLAG_C] = 1'b0;
      SRF_NEGATIVE_SET_OP: exp_flags[`SRF_FLAG_N] = 1'b1;
      SRF_NEGATIVE_CLEAR_OP: exp_flags[`SRF_FLAG_N] = 1'b0;
      SRF_ZERO_SET_OP: exp_flags[`SRF_FLAG_Z] = 1'b1;
      SRF_ZERO_CLEAR_OP: exp_flags[`SRF_FLAG_Z] = 1'b0;
      default: ;
    endcase
    if (shf) begin
      exp_flags[`SRF_FLAG_C] = (op == SRF_ROTATE_LEFT_CARRY) ? v[7] : v[0];
      exp_flags[`SRF_FLAG_Z] = (r == 8'h00);
      exp_flags[`SRF_FLAG_N] = r[7];
      exp_flags[`SRF_FLAG_V] = r[7] ^ exp_flags[`SRF_FLAG_C];
    end
    exp_reg[d] = r;
    @(negedge SYS_CLK);
    OP_VALID = 1'b1;
    OP_CODE = op;
    INT_ENABLE_OP = ie;
    DEST_SEL = d;
    SRC_SEL = s;
    BIT_INDEX = b;
    @(negedge SYS_CLK);
    OP_VALID = 1'b0;
    INT_ENABLE_OP = 1'b0;
    check8({7'h00, BUSY}, 8'h01, "busy in execute");
    @(negedge SYS_CLK);
    check8({7'h00, BUSY}, 8'h00, "busy after writeback");
    check8(STATUS_FLAGS, exp_flags, "flags");
    if (!ie && op != SRF_NOP && (op <= SRF_NIBBLE_SWAP || op == SRF_TRANSFER_TO_REG_BIT))
      check8(RESULT, r, "result");
    if (!ie && (op <= SRF_NIBBLE_SWAP || op == SRF_TRANSFER_TO_REG_BIT)) peek(d);
  endtask : run_op

  // Watchdog against a hung sequence
  initial begin : watchdog
    repeat (20000) @(posedge SYS_CLK);
    n_errors++;
    $display("[FAIL] %0t run did not finish in time", $time);
    complete_run();
  end

  initial begin : main
    for (int i = 0; i < 32; i++) exp_reg[i] = `SRF_REG_RST;
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST_N = 1'b1;
    check8(STATUS_FLAGS, `SRF_FLAGS_RST, "flags after reset");
    check8(RESULT, 8'h00, "result after reset");
    load(5'h01, 8'h01);
    load(5'h02, 8'h80);
    load(5'h03, 8'hB6);
    load(5'h1F, 8'h81);
    run_op(SRF_LOGICAL_RIGHT_SHIFT, 5'h01, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ROTATE_RIGHT_CARRY, 5'h03, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ROTATE_LEFT_CARRY, 5'h02, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ROTATE_LEFT_CARRY, 5'h03, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ROTATE_RIGHT_CARRY, 5'h1F, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ARITH_RIGHT_SHIFT, 5'h1F, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ARITH_RIGHT_SHIFT, 5'h1F, 5'h00, 3'h0, 1'b0);
    run_op(SRF_LOGICAL_RIGHT_SHIFT, 5'h1F, 5'h00, 3'h0, 1'b0);
    run_op(SRF_NIBBLE_SWAP, 5'h03, 5'h00, 3'h0, 1'b0);
    for (int b = 0; b < 8; b++) begin
      run_op(SRF_FLAG_SET_BY_INDEX, 5'h00, 5'h00, b[2:0], 1'b0);
    end
    run_op(SRF_CARRY_CLEAR_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_NEGATIVE_CLEAR_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ZERO_CLEAR_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_NIBBLE_SWAP, 5'h1F, 5'h00, 3'h0, 1'b0);
    for (int b = 7; b >= 0; b--) begin
      run_op(SRF_FLAG_CLEAR_BY_INDEX, 5'h00, 5'h00, b[2:0], 1'b0);
    end
    run_op(SRF_CARRY_SET_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_NEGATIVE_SET_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_ZERO_SET_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_CARRY_CLEAR_OP, 5'h00, 5'h00, 3'h0, 1'b0);
    run_op(SRF_CARRY_SET_OP, 5'h00, 5'h00, 3'h0, 1'b1);
    run_op(SRF_REG_BIT_TO_TRANSFER, 5'h00, 5'h03, 3'h0, 1'b0);
    run_op(SRF_TRANSFER_TO_REG_BIT, 5'h04, 5'h00, 3'h6, 1'b0);
    run_op(SRF_REG_BIT_TO_TRANSFER, 5'h00, 5'h02, 3'h0, 1'b0);
    run_op(SRF_TRANSFER_TO_REG_BIT, 5'h1F, 5'h00, 3'h7, 1'b0);
    complete_run();
  end
endmodule : tb_srf_unit
`default_nettype wire
